// >>> efs_pkg.sv
/*
 * Shared constants and types of the engine fault supervisor.
 * Assumes a 100 MHz system clock; every time is given in ms and turned into cycles here.
 */
package efs_pkg;

	// ----------------------------------------------------------------
	// Clock and timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_HZ         = 100_000_000;
	localparam int unsigned CYC_PER_MS     = CLK_HZ / 1000;
	localparam int unsigned RX_SHUT_MS     = 2000;
	localparam int unsigned MAIN_SHUT_MS   = 5000;
	localparam int unsigned WARN_MS        = 5000;
	localparam int unsigned BLOCK_MS       = 5000;
	localparam int unsigned ARM_MS         = 7000;
	localparam int unsigned LIVE_MS        = 10000;
	localparam int unsigned SHOW_MS        = 3000;
	localparam int unsigned CONFIRM_MS     = 3000;
	localparam int unsigned LOSS_LOW_MS    = 500;
	localparam int unsigned LOSS_MED_MS    = 200;
	localparam int unsigned LOSS_HIGH_MS   = 100;
	localparam int unsigned RX_SHUT_CYC    = RX_SHUT_MS * CYC_PER_MS;
	localparam int unsigned MAIN_SHUT_CYC  = MAIN_SHUT_MS * CYC_PER_MS;
	localparam int unsigned WARN_CYC       = WARN_MS * CYC_PER_MS;
	localparam int unsigned BLOCK_CYC      = BLOCK_MS * CYC_PER_MS;
	localparam int unsigned ARM_CYC        = ARM_MS * CYC_PER_MS;
	localparam int unsigned LIVE_CYC       = LIVE_MS * CYC_PER_MS;
	localparam int unsigned SHOW_CYC       = SHOW_MS * CYC_PER_MS;
	localparam int unsigned CONFIRM_CYC    = CONFIRM_MS * CYC_PER_MS;
	localparam int unsigned LOSS_LOW_CYC   = LOSS_LOW_MS * CYC_PER_MS;
	localparam int unsigned LOSS_MED_CYC   = LOSS_MED_MS * CYC_PER_MS;
	localparam int unsigned LOSS_HIGH_CYC  = LOSS_HIGH_MS * CYC_PER_MS;

	// ----------------------------------------------------------------
	// Signal and persistence channels
	// ----------------------------------------------------------------
	localparam int unsigned SIG_W          = 7;
	localparam int unsigned NCH            = 4;
	localparam int unsigned CH_RX_SHUT     = 0;
	localparam int unsigned CH_MAIN_SHUT   = 1;
	localparam int unsigned CH_RX_WARN     = 2;
	localparam int unsigned CH_MAIN_WARN   = 3;
	localparam logic        LIMIT_EN_RST   = 1'b0;

	typedef enum logic [2:0] {
		CODE_NONE       = 3'h0,
		CODE_RX_ERROR   = 3'h1,
		CODE_KILL_OFF   = 3'h2,
		CODE_RX_DEAD    = 3'h3,
		CODE_MAIN_DEAD  = 3'h4,
		CODE_RX_LOW     = 3'h5,
		CODE_MAIN_LOW   = 3'h6
	} efs_code_e;

	typedef enum logic [1:0] {
		SENS_OFF  = 2'h0,
		SENS_LOW  = 2'h1,
		SENS_MED  = 2'h2,
		SENS_HIGH = 2'h3
	} efs_sens_e;

	localparam efs_sens_e SENS_RST = SENS_LOW;

	typedef enum logic [2:0] {
		PG_IDLE    = 3'h0,
		PG_SHOW    = 3'h1,
		PG_LIVE    = 3'h2,
		PG_EDIT    = 3'h3,
		PG_CONFIRM = 3'h4
	} efs_prog_e;

	function automatic logic efs_is_shutdown(input efs_code_e c);
		efs_is_shutdown = (c == CODE_RX_ERROR) || (c == CODE_KILL_OFF) ||
				  (c == CODE_RX_DEAD) || (c == CODE_MAIN_DEAD);
	endfunction : efs_is_shutdown

endpackage : efs_pkg

// >>> efs_persist_if.sv
/*
 * Carrier between the supervisor and its persistence timers.
 * Assumes both ends sit in the same clock domain.
 */
`timescale 1ns/1ps
`default_nettype none

interface efs_persist_if #(parameter int unsigned N = 4);
	logic [N-1:0] cond;
	logic [N-1:0] expired;
	logic         clear;

	modport owner (output cond, output clear, input expired);
	modport timer (input cond, input clear, output expired);
endinterface : efs_persist_if

`default_nettype wire

// >>> efs_persist.sv
/*
 * Persistence timers: each channel flags once its condition has held without break
 * for its limit in cycles. Assumes conditions are synchronous to clock_i.
 */
`timescale 1ns/1ps
`default_nettype none

module efs_persist #(
	parameter int unsigned N            = 4,
	parameter int unsigned LIMIT [N]    = '{default: 1}
) (
	input  wire logic       clock_i,
	input  wire logic       reset_n_i,
	efs_persist_if.timer    pif
);
	logic [31:0]  cnt_r   [N];
	logic [31:0]  cnt_nxt [N];
	logic [N-1:0] exp_r;
	logic [N-1:0] exp_nxt;

	generate
		for (genvar g = 0; g < N; g++) begin : g_chk
			if (LIMIT[g] < 1) begin : g_bad
				$error("efs_persist: limit below one cycle");
			end
		end
	endgenerate

	// A break in the condition restarts the count: only an unbroken stretch counts
	always_comb begin
		for (int i = 0; i < N; i++) begin
			cnt_nxt[i] = cnt_r[i];
			exp_nxt[i] = exp_r[i];
			if (pif.clear || !pif.cond[i]) begin
				cnt_nxt[i] = 32'h0;
				exp_nxt[i] = 1'b0;
			end else if (cnt_r[i] < LIMIT[i]) begin
				cnt_nxt[i] = cnt_r[i] + 32'h1;
				exp_nxt[i] = (cnt_r[i] + 32'h1) >= LIMIT[i];
			end
		end
	end

	always_ff @(posedge clock_i) begin
		if (!reset_n_i) begin
			for (int i = 0; i < N; i++) begin
				cnt_r[i] <= 32'h0;
			end
			exp_r <= '0;
		end else begin
			cnt_r <= cnt_nxt;
			exp_r <= exp_nxt;
		end
	end

	assign pif.expired = exp_r;

endmodule : efs_persist

`default_nettype wire

// >>> efs_supervisor.sv
/*
 * Engine fault supervisor: receiver signal and battery supervision, fault code latch,
 * restart lockout, misfire request and the receiver-limit programming sequence.
 * Assumes all inputs synchronous to clock_i; battery comparisons are made outside.
 */
`timescale 1ns/1ps
`default_nettype none

// How it works
// - A warning or shutdown latches its fault code on fault_code_o if none is latched; a shutdown replaces a latched warning.
// - After a supervision shutdown, engine starts are refused for 5 seconds.
// - Latched faults clear only on an accepted engine start or reset.
// - Receiver value above upper or below lower limit kills engine, kill-switch code.
// - No valid receiver sample for sensitivity timeout kills engine, receiver-error code.
// - Sensitivity is 1 low (reset), 2 medium or 3 high; higher is faster.
// - Programming shows the stored lower limit, live value 10 s, takes new values, confirms.
// - Receiver supervision is armed only 7 seconds after reset.
// - Limits and sensitivity change only while the engine is stopped.
module efs_supervisor
	import efs_pkg::*;
#(
	parameter int unsigned W          = SIG_W,
	parameter int unsigned ARM_N      = ARM_CYC,
	parameter int unsigned RX_SHUT_N  = RX_SHUT_CYC,
	parameter int unsigned MAIN_SHUT_N = MAIN_SHUT_CYC,
	parameter int unsigned WARN_N     = WARN_CYC,
	parameter int unsigned BLOCK_N    = BLOCK_CYC,
	parameter int unsigned SHOW_N     = SHOW_CYC,
	parameter int unsigned LIVE_N     = LIVE_CYC,
	parameter int unsigned CONFIRM_N  = CONFIRM_CYC,
	parameter int unsigned LOSS_LOW_N = LOSS_LOW_CYC,
	parameter int unsigned LOSS_MED_N = LOSS_MED_CYC,
	parameter int unsigned LOSS_HIGH_N = LOSS_HIGH_CYC
) (
	input  wire logic            clock_i,
	input  wire logic            reset_n_i,
	input  wire logic [W-1:0]    rx_value_i,
	input  wire logic            rx_valid_i,
	input  wire logic            rx_batt_below_shut_i,
	input  wire logic            rx_batt_below_warn_i,
	input  wire logic            main_batt_below_shut_i,
	input  wire logic            main_batt_below_warn_i,
	input  wire logic            engine_running_i,
	input  wire logic            engine_start_i,
	input  wire logic [15:0]     engine_speed_i,
	input  wire logic [15:0]     allowed_max_speed_i,
	input  wire logic            prog_start_i,
	input  wire logic            cfg_write_i,
	input  wire logic [W-1:0]    cfg_lower_i,
	input  wire logic            cfg_lower_en_i,
	input  wire logic [W-1:0]    cfg_upper_i,
	input  wire logic            cfg_upper_en_i,
	input  wire logic [1:0]      cfg_sens_i,
	output logic                 kill_o,
	output logic                 misfire_o,
	output logic                 restart_block_o,
	output logic                 start_grant_o,
	output efs_code_e            fault_code_o,
	output efs_prog_e            prog_phase_o,
	output logic [W-1:0]         display_value_o,
	output logic [W-1:0]         signal_lower_limit_o,
	output logic [W-1:0]         signal_upper_limit_o,
	output logic                 lower_en_o,
	output logic                 upper_en_o,
	output efs_sens_e            glitch_sensitivity_o
);
	// ----------------------------------------------------------------
	// Elaboration checks
	// ----------------------------------------------------------------
	if (W < 1 || W > 16) begin : g_bad_w
		$error("efs_supervisor: signal width out of range");
	end
	if (ARM_N < 1 || BLOCK_N < 1 || SHOW_N < 1 || LIVE_N < 1 || CONFIRM_N < 1 ||
	    LOSS_HIGH_N < 1 || LOSS_HIGH_N > LOSS_MED_N || LOSS_MED_N > LOSS_LOW_N) begin : g_bad_t
		$error("efs_supervisor: timing count out of range");
	end

	function automatic logic [31:0] loss_limit(input efs_sens_e s);
		unique case (s)
			SENS_HIGH: loss_limit = LOSS_HIGH_N;
			SENS_MED:  loss_limit = LOSS_MED_N;
			default:   loss_limit = LOSS_LOW_N;
		endcase
	endfunction : loss_limit

	// ----------------------------------------------------------------
	// Battery persistence timers
	// ----------------------------------------------------------------
	efs_persist_if #(.N(NCH)) pif ();

	efs_persist #(
		.N     (NCH),
		.LIMIT ('{RX_SHUT_N, MAIN_SHUT_N, WARN_N, WARN_N})
	) u_persist (
		.clock_i   (clock_i),
		.reset_n_i (reset_n_i),
		.pif       (pif.timer)
	);

	logic        start_ok;
	assign start_ok = engine_start_i && !restart_block_o;

	assign pif.cond[CH_RX_SHUT]   = rx_batt_below_shut_i;
	assign pif.cond[CH_MAIN_SHUT] = main_batt_below_shut_i;
	assign pif.cond[CH_RX_WARN]   = rx_batt_below_warn_i;
	assign pif.cond[CH_MAIN_WARN] = main_batt_below_warn_i;
	assign pif.clear              = start_ok;

	// ----------------------------------------------------------------
	// Supervision, fault latch and restart lockout
	// ----------------------------------------------------------------
	logic [31:0] arm_cnt_r, arm_cnt_nxt, loss_cnt_r, loss_cnt_nxt, blk_cnt_r, blk_cnt_nxt;
	logic        armed_r, armed_nxt, warn_r, warn_nxt, kill_nxt, misfire_nxt;
	efs_code_e   code_nxt, evt_code;
	logic        sup_en, out_range, loss_evt;

	always_comb begin
		sup_en      = armed_r && lower_en_o && upper_en_o;
		out_range   = rx_valid_i && ((rx_value_i > signal_upper_limit_o) ||
				 (rx_value_i < signal_lower_limit_o));
		arm_cnt_nxt = (arm_cnt_r < ARM_N) ? arm_cnt_r + 32'h1 : arm_cnt_r;
		armed_nxt   = arm_cnt_nxt >= ARM_N;
		loss_cnt_nxt = (rx_valid_i || !sup_en) ? 32'h0 :
			       (loss_cnt_r < loss_limit(glitch_sensitivity_o)) ? loss_cnt_r + 32'h1 :
			       loss_cnt_r;
		loss_evt    = sup_en && (loss_cnt_r >= loss_limit(glitch_sensitivity_o));
		// Fixed priority when several faults arrive together
		if (loss_evt)                              evt_code = CODE_RX_ERROR;
		else if (sup_en && out_range)              evt_code = CODE_KILL_OFF;
		else if (pif.expired[CH_RX_SHUT])          evt_code = CODE_RX_DEAD;
		else if (pif.expired[CH_MAIN_SHUT])        evt_code = CODE_MAIN_DEAD;
		else if (pif.expired[CH_RX_WARN])          evt_code = CODE_RX_LOW;
		else if (pif.expired[CH_MAIN_WARN])        evt_code = CODE_MAIN_LOW;
		else                                       evt_code = CODE_NONE;
		// A fault in the very cycle of a start is kept, not lost
		code_nxt = start_ok ? CODE_NONE : fault_code_o;
		if (evt_code != CODE_NONE && (code_nxt == CODE_NONE ||
		    (efs_is_shutdown(evt_code) && !efs_is_shutdown(code_nxt)))) begin
			code_nxt = evt_code;
		end
		kill_nxt    = efs_is_shutdown(code_nxt);
		warn_nxt    = (start_ok ? 1'b0 : warn_r) ||
			      pif.expired[CH_RX_WARN] || pif.expired[CH_MAIN_WARN];
		misfire_nxt = warn_r && !kill_o &&
			      (engine_speed_i >= {1'b0, allowed_max_speed_i[15:1]});
		blk_cnt_nxt = (kill_nxt && !kill_o) ? BLOCK_N :
			      (blk_cnt_r != 32'h0) ? blk_cnt_r - 32'h1 : 32'h0;
	end

	always_ff @(posedge clock_i) begin
		if (!reset_n_i) begin
			arm_cnt_r       <= 32'h0;
			armed_r         <= 1'b0;
			loss_cnt_r      <= 32'h0;
			fault_code_o    <= CODE_NONE;
			kill_o          <= 1'b0;
			warn_r          <= 1'b0;
			misfire_o       <= 1'b0;
			blk_cnt_r       <= 32'h0;
			restart_block_o <= 1'b0;
			start_grant_o   <= 1'b0;
		end else begin
			arm_cnt_r       <= arm_cnt_nxt;
			armed_r         <= armed_nxt;
			loss_cnt_r      <= loss_cnt_nxt;
			fault_code_o    <= code_nxt;
			kill_o          <= kill_nxt;
			warn_r          <= warn_nxt;
			misfire_o       <= misfire_nxt;
			blk_cnt_r       <= blk_cnt_nxt;
			restart_block_o <= blk_cnt_nxt != 32'h0;
			start_grant_o   <= start_ok;
		end
	end

	// ----------------------------------------------------------------
	// Limit programming sequence
	// ----------------------------------------------------------------
	efs_prog_e   prog_nxt;
	logic [31:0] pg_cnt_r, pg_cnt_nxt;
	logic [W-1:0] disp_nxt, lower_nxt, upper_nxt;
	logic        lower_en_nxt, upper_en_nxt;
	efs_sens_e   sens_nxt;

	always_comb begin
		prog_nxt     = prog_phase_o;
		pg_cnt_nxt   = (pg_cnt_r != 32'h0) ? pg_cnt_r - 32'h1 : 32'h0;
		disp_nxt     = display_value_o;
		lower_nxt    = signal_lower_limit_o;
		upper_nxt    = signal_upper_limit_o;
		lower_en_nxt = lower_en_o;
		upper_en_nxt = upper_en_o;
		sens_nxt     = glitch_sensitivity_o;
		// A running engine aborts programming
		if (engine_running_i && prog_phase_o != PG_IDLE) begin
			prog_nxt   = PG_IDLE;
			pg_cnt_nxt = 32'h0;
		end else begin
			unique case (prog_phase_o)
				PG_IDLE: if (prog_start_i && !engine_running_i) begin
					prog_nxt   = PG_SHOW;
					pg_cnt_nxt = SHOW_N;
					disp_nxt   = signal_lower_limit_o;
				end
				PG_SHOW: if (pg_cnt_r == 32'h1) begin
					prog_nxt   = PG_LIVE;
					pg_cnt_nxt = LIVE_N;
				end
				PG_LIVE: begin
					if (rx_valid_i) disp_nxt = rx_value_i;
					if (pg_cnt_r == 32'h1) prog_nxt = PG_EDIT;
				end
				PG_EDIT: if (cfg_write_i) begin
					prog_nxt     = PG_CONFIRM;
					pg_cnt_nxt   = CONFIRM_N;
					lower_nxt    = cfg_lower_i;
					upper_nxt    = cfg_upper_i;
					lower_en_nxt = cfg_lower_en_i;
					upper_en_nxt = cfg_upper_en_i;
					// An illegal setting keeps the old one
					if (cfg_sens_i != SENS_OFF) sens_nxt = efs_sens_e'(cfg_sens_i);
					disp_nxt     = cfg_lower_i;
				end
				PG_CONFIRM: if (pg_cnt_r == 32'h1) prog_nxt = PG_IDLE;
				default: prog_nxt = PG_IDLE;
			endcase
		end
	end

	always_ff @(posedge clock_i) begin
		if (!reset_n_i) begin
			prog_phase_o         <= PG_IDLE;
			pg_cnt_r             <= 32'h0;
			display_value_o      <= '0;
			signal_lower_limit_o <= '0;
			signal_upper_limit_o <= '0;
			lower_en_o           <= LIMIT_EN_RST;
			upper_en_o           <= LIMIT_EN_RST;
			glitch_sensitivity_o <= SENS_RST;
		end else begin
			prog_phase_o         <= prog_nxt;
			pg_cnt_r             <= pg_cnt_nxt;
			display_value_o      <= disp_nxt;
			signal_lower_limit_o <= lower_nxt;
			signal_upper_limit_o <= upper_nxt;
			lower_en_o           <= lower_en_nxt;
			upper_en_o           <= upper_en_nxt;
			glitch_sensitivity_o <= sens_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!reset_n_i);

	property p_kill_off_on_range;
		fault_code_o == CODE_NONE && !loss_evt && sup_en && out_range && !start_ok
			|=> fault_code_o == CODE_KILL_OFF && kill_o;
	endproperty
	a_kill_off_on_range: assert property (p_kill_off_on_range) else $error("range kill missed");

	property p_limit_inclusive;
		fault_code_o == CODE_NONE && rx_valid_i &&
		(rx_value_i == signal_lower_limit_o || rx_value_i == signal_upper_limit_o)
			|=> fault_code_o != CODE_KILL_OFF;
	endproperty
	a_limit_inclusive: assert property (p_limit_inclusive) else $error("limit value killed");

	property p_block_after_kill;
		$rose(kill_o) |-> restart_block_o ##1 restart_block_o;
	endproperty
	a_block_after_kill: assert property (p_block_after_kill) else $error("no restart lockout");

	property p_start_refused;
		restart_block_o && engine_start_i |=> !start_grant_o && $stable(fault_code_o);
	endproperty
	a_start_refused: assert property (p_start_refused) else $error("start during lockout");

	property p_code_sticky;
		fault_code_o != CODE_NONE && !start_ok |=> fault_code_o != CODE_NONE;
	endproperty
	a_code_sticky: assert property (p_code_sticky) else $error("fault code lost");

	property p_kill_shows_code;
		kill_o |-> efs_is_shutdown(fault_code_o);
	endproperty
	a_kill_shows_code: assert property (p_kill_shows_code) else $error("kill without code");

	property p_not_armed;
		!armed_r |-> fault_code_o != CODE_KILL_OFF && fault_code_o != CODE_RX_ERROR;
	endproperty
	a_not_armed: assert property (p_not_armed) else $error("receiver fault before arming");

	property p_sens_legal;
		glitch_sensitivity_o != SENS_OFF;
	endproperty
	a_sens_legal: assert property (p_sens_legal) else $error("illegal sensitivity");

	property p_cfg_frozen;
		engine_running_i |=> $stable(signal_lower_limit_o) && $stable(signal_upper_limit_o) &&
			$stable(glitch_sensitivity_o);
	endproperty
	a_cfg_frozen: assert property (p_cfg_frozen) else $error("config changed while running");

	property p_live_display;
		prog_phase_o == PG_LIVE && rx_valid_i && !engine_running_i
			|=> display_value_o == $past(rx_value_i);
	endproperty
	a_live_display: assert property (p_live_display) else $error("live value not shown");

	property p_misfire_cause;
		misfire_o |-> $past(warn_r) && !$past(kill_o);
	endproperty
	a_misfire_cause: assert property (p_misfire_cause) else $error("misfire without warning");

	c_range_kill: cover property ($rose(kill_o) && fault_code_o == CODE_KILL_OFF);
	c_loss_kill:  cover property ($rose(kill_o) && fault_code_o == CODE_RX_ERROR);
	c_misfire:    cover property ($rose(misfire_o));
	c_prog_done:  cover property (prog_phase_o == PG_CONFIRM ##1 prog_phase_o == PG_IDLE);

endmodule : efs_supervisor

`default_nettype wire

// >>> efs_end.sv
/*
 * Holds no logic: every module of the supervisor sits in a file of its own.
 * Assumes nothing of its surroundings.
 */

// >>> efs_rx_model.sv
/*
 * Receiver channel model: one valid sample every PER cycles while running.
 * Assumes the bench sets level and run enable just after the clock edge.
 */
`timescale 1ns/1ps
`default_nettype none

module efs_rx_model #(
	parameter int unsigned PER = 3
) (
	input  wire logic       clock_i,
	input  wire logic       run_i,
	input  wire logic [6:0] level_i,
	output logic [6:0]      rx_value_o,
	output logic            rx_valid_o
);
	// ----------------------------------------------------------------
	// Sample pacing
	// ----------------------------------------------------------------
	int unsigned cnt;

	initial begin
		cnt = 0;
		rx_valid_o = 1'b0;
		rx_value_o = 7'h00;
	end

	// Stopping run_i is a lost signal; between strobes the value line carries junk
	always @(posedge clock_i) begin
		cnt <= (cnt + 1) % PER;
		rx_valid_o <= run_i && cnt == 0;
		rx_value_o <= (run_i && cnt == 0) ? level_i : ~rx_value_o;
	end
endmodule : efs_rx_model

`default_nettype wire

// >>> efs_supervisor_tb_top.sv
/*
 * Self-checking bench of the engine fault supervisor with shortened timers.
 * Assumes efs_pkg, efs_persist_if, efs_persist and the receiver model are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none

module efs_supervisor_tb_top;
	import efs_pkg::*;
	// ----------------------------------------------------------------
	// Shortened timers
	// ----------------------------------------------------------------
	localparam int unsigned ARM = 200, RXS = 20, MNS = 30, WRN = 30, BLK = 30;
	localparam int unsigned SHW = 10, LIV = 20, CNF = 10;
	localparam int unsigned LOSS [4] = '{0, 16, 8, 4};
	logic clock_i = 1'b0, reset_n_i = 1'b0, run = 1'b1;
	logic [6:0] level = 7'h32, rx_value_i, cfg_lower_i = 7'h00, cfg_upper_i = 7'h00;
	logic rx_valid_i, rx_batt_below_shut_i = 1'b0, rx_batt_below_warn_i = 1'b0;
	logic main_batt_below_shut_i = 1'b0, main_batt_below_warn_i = 1'b0;
	logic engine_running_i = 1'b0, engine_start_i = 1'b0, prog_start_i = 1'b0;
	logic cfg_write_i = 1'b0, cfg_lower_en_i = 1'b0, cfg_upper_en_i = 1'b0;
	logic [1:0] cfg_sens_i = 2'h0;
	logic [15:0] engine_speed_i = 16'h0000, allowed_max_speed_i = 16'h03e8;
	logic kill_o, misfire_o, restart_block_o, start_grant_o, lower_en_o, upper_en_o;
	logic [6:0] display_value_o, signal_lower_limit_o, signal_upper_limit_o;
	efs_code_e fault_code_o;
	efs_prog_e prog_phase_o;
	efs_sens_e glitch_sensitivity_o;
	logic [6:0] cur_lo = 7'h00;
	logic [1:0] cur_sens = 2'h1;
	int mismatches = 0, num_checks = 0, cycles = 0;

	efs_supervisor #(.ARM_N(ARM), .RX_SHUT_N(RXS), .MAIN_SHUT_N(MNS), .WARN_N(WRN),
		.BLOCK_N(BLK), .SHOW_N(SHW), .LIVE_N(LIV), .CONFIRM_N(CNF),
		.LOSS_LOW_N(16), .LOSS_MED_N(8), .LOSS_HIGH_N(4)) i_efs_supervisor (
		.clock_i, .reset_n_i, .rx_value_i, .rx_valid_i, .rx_batt_below_shut_i,
		.rx_batt_below_warn_i, .main_batt_below_shut_i, .main_batt_below_warn_i,
		.engine_running_i, .engine_start_i, .engine_speed_i, .allowed_max_speed_i,
		.prog_start_i, .cfg_write_i, .cfg_lower_i, .cfg_lower_en_i, .cfg_upper_i,
		.cfg_upper_en_i, .cfg_sens_i, .kill_o, .misfire_o, .restart_block_o,
		.start_grant_o, .fault_code_o, .prog_phase_o, .display_value_o,
		.signal_lower_limit_o, .signal_upper_limit_o, .lower_en_o, .upper_en_o,
		.glitch_sensitivity_o);

	efs_rx_model #(.PER(3)) i_efs_rx_model (.clock_i, .run_i(run), .level_i(level),
		.rx_value_o(rx_value_i), .rx_valid_o(rx_valid_i));

	always #5 clock_i = ~clock_i;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic summarize();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : summarize

	// A hang is cut short well above the expected run of about 1160 cycles
	always @(posedge clock_i) begin
		cycles++;
		if (cycles == 4000) begin
			mismatches++;
			summarize();
		end
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic step(input int n);
		repeat (n) @(posedge clock_i);
		#1;
	endtask : step

	task automatic wait_code(output int n, input int hi);
		n = 0;
		while (fault_code_o === CODE_NONE && n < hi) begin
			step(1);
			n++;
		end
	endtask : wait_code

	task automatic do_start(input logic g);
		engine_start_i = 1'b1;
		step(1);
		engine_start_i = 1'b0;
		check(start_grant_o, g);
	endtask : do_start

	task automatic clear_fault();
		step(BLK);
		do_start(1'b1);
		check(fault_code_o, CODE_NONE);
		check(kill_o, 1'b0);
	endtask : clear_fault

	task automatic set_b(input int ch, input logic v);
		case (ch)
			0: rx_batt_below_shut_i = v;
			1: main_batt_below_shut_i = v;
			2: rx_batt_below_warn_i = v;
			default: main_batt_below_warn_i = v;
		endcase
	endtask : set_b

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		check({kill_o, misfire_o, restart_block_o, start_grant_o, lower_en_o, upper_en_o}, 0);
		check(fault_code_o, CODE_NONE);
		check(glitch_sensitivity_o, SENS_LOW);
	endtask : t_reset

	task automatic t_lockout();
		engine_running_i = 1'b1;
		prog_start_i = 1'b1;
		step(1);
		prog_start_i = 1'b0;
		check(prog_phase_o, PG_IDLE);
		engine_running_i = 1'b0;
		prog_start_i = 1'b1;
		step(1);
		prog_start_i = 1'b0;
		check(prog_phase_o, PG_SHOW);
		engine_running_i = 1'b1;
		step(2);
		check(prog_phase_o, PG_IDLE);
		check(lower_en_o, 1'b0);
		engine_running_i = 1'b0;
	endtask : t_lockout

	task automatic t_prog(input logic [6:0] l, input logic [6:0] u, input logic [1:0] s);
		prog_start_i = 1'b1;
		step(1);
		prog_start_i = 1'b0;
		check(prog_phase_o, PG_SHOW);
		check(display_value_o, cur_lo);
		step(SHW);
		check(prog_phase_o, PG_LIVE);
		step(LIV - 1);
		check(display_value_o, level);
		step(1);
		check(prog_phase_o, PG_EDIT);
		{cfg_lower_i, cfg_upper_i, cfg_sens_i} = {l, u, s};
		{cfg_lower_en_i, cfg_upper_en_i, cfg_write_i} = 3'h7;
		step(1);
		cfg_write_i = 1'b0;
		check(prog_phase_o, PG_CONFIRM);
		if (s != 2'h0) cur_sens = s;
		cur_lo = l;
		check({signal_lower_limit_o, signal_upper_limit_o, glitch_sensitivity_o},
			{l, u, cur_sens});
		check({display_value_o, lower_en_o, upper_en_o}, {l, 2'h3});
		step(CNF);
		check(prog_phase_o, PG_IDLE);
	endtask : t_prog

	task automatic t_arm();
		logic [6:0] outs [2] = '{7'h4f, 7'h18};
		int n;
		level = 7'h5a;
		step(100);
		check(fault_code_o, CODE_NONE);
		level = 7'h4e;
		step(ARM);
		check(fault_code_o, CODE_NONE);
		level = 7'h19;
		step(12);
		check(fault_code_o, CODE_NONE);
		foreach (outs[i]) begin
			level = outs[i];
			wait_code(n, 9);
			check(fault_code_o, CODE_KILL_OFF);
			check({kill_o, restart_block_o}, 2'h3);
			level = 7'h32;
			step(BLK - 8);
			do_start(1'b0);
			check(fault_code_o, CODE_KILL_OFF);
			clear_fault();
		end
	endtask : t_arm

	task automatic t_loss();
		int n;
		for (int s = 1; s < 4; s++) begin
			t_prog(7'h19, 7'h4e, s[1:0]);
			run = 1'b0;
			wait_code(n, LOSS[s] + 8);
			check(fault_code_o, CODE_RX_ERROR);
			check(n >= LOSS[s] - 3 && n <= LOSS[s] + 3, 1'b1);
			run = 1'b1;
			clear_fault();
		end
	endtask : t_loss

	task automatic t_batt(input int ch, input int lim, input efs_code_e c, input logic k);
		int n;
		set_b(ch, 1'b1);
		step(lim - 3);
		set_b(ch, 1'b0);
		step(1);
		set_b(ch, 1'b1);
		check(fault_code_o, CODE_NONE);
		wait_code(n, lim + 4);
		check(fault_code_o, c);
		check(kill_o, k);
		check(n, lim + 1);
		if (!k) begin
			engine_speed_i = 16'h01f3;
			step(2);
			check(misfire_o, 1'b0);
			engine_speed_i = 16'h01f4;
			step(2);
			check(misfire_o, 1'b1);
		end
		set_b(ch, 1'b0);
		clear_fault();
	endtask : t_batt

	// A latched shutdown must also fall away on a reset in mid-run
	task automatic t_rst_clear();
		int n;
		set_b(1, 1'b1);
		wait_code(n, MNS + 4);
		set_b(1, 1'b0);
		check(kill_o, 1'b1);
		reset_n_i = 1'b0;
		step(2);
		reset_n_i = 1'b1;
		t_reset();
	endtask : t_rst_clear

	initial begin
		step(12);
		reset_n_i = 1'b1;
		t_reset();
		t_lockout();
		// Observed span 28..73 widened to 25..78
		t_prog(7'h19, 7'h4e, 2'h1);
		t_arm();
		t_loss();
		t_prog(7'h19, 7'h4e, 2'h0);
		t_batt(0, RXS, CODE_RX_DEAD, 1'b1);
		t_batt(1, MNS, CODE_MAIN_DEAD, 1'b1);
		t_batt(2, WRN, CODE_RX_LOW, 1'b0);
		t_batt(3, WRN, CODE_MAIN_LOW, 1'b0);
		t_rst_clear();
		summarize();
	end
endmodule : efs_supervisor_tb_top

`default_nettype wire
